// File: logic/scl_top.v
// slot role selection, arbiter and clock steering, eeprom loader, axi4-lite registers
`timescale 1ns/1ps
`include "scl_map.vh"

// Overview of operation
// - role selector offers auto (default), forced non-slot-0, forced slot-0.
// - in auto, take system controller role only when slot 0 is sensed.
// - as controller, arbitrate four request levels and grant the highest.
// - as controller, enable driving the 16 MHz system clock from onboard oscillator.
// - drive CLK10 only in slot 0; elsewhere only receive it.
// - switch picks CLK10 source; internal by default, external coaxial otherwise.
// - software may route backplane CLK10 out to the coaxial connector.
// - 50 ohm termination has no effect while internal source is selected.
// - at power-up load eeprom words so manager accesses are served within 5 s.
// - jumper enables self configuration by default; disabled leaves backplane unusable.
// - eeprom has factory and user halves; jumper picks, user by default.
module scl_top
#(
   parameter DEADLINE_CYC = `SCL_LOAD_DEADLINE_S * `SCL_CLK_HZ
)
(
   input  wire        aclk,
   input  wire        aresetn,
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   input  wire [1:0]  slot_role_selector,
   input  wire        slot0_sense_n,
   input  wire        ref_clock_source_switch,
   input  wire        self_config_enable_jumper,
   input  wire        config_half_select_jumper,
   input  wire [3:0]  bus_req_n,
   output wire [3:0]  bus_grant,
   output reg         sysclk_drive_en,
   output reg         clk10_drive_en,
   output reg         clk10_ext_sel,
   output reg         clk10_coax_out_en,
   output reg         clk10_term50_en,
   input  wire [15:0] ee_data,
   output wire [3:0]  ee_addr,
   output wire        ee_rd,
   output reg         backplane_ready
);

// ****************************************************************
// pin synchronisers
// ****************************************************************
   reg  [9:0]  pin_s1_q;
   reg  [9:0]  pin_s2_q;
   reg  [15:0] ee_s1_q;
   reg  [15:0] ee_s2_q;
   wire [9:0]  pins_raw;

   assign pins_raw = {bus_req_n, config_half_select_jumper, self_config_enable_jumper,
                      ref_clock_source_switch, slot0_sense_n, slot_role_selector};

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pin_s1_q <= 10'h3ff;
         pin_s2_q <= 10'h3ff;
         ee_s1_q  <= 16'h0000;
         ee_s2_q  <= 16'h0000;
      end
      else
      begin
         pin_s1_q <= pins_raw;
         pin_s2_q <= pin_s1_q;
         ee_s1_q  <= ee_data;
         ee_s2_q  <= ee_s1_q;
      end
   end

// ****************************************************************
// strap capture after reset release
// ****************************************************************
   // straps are caught once so the role never changes under a live bus
   reg [2:0] settle_q;
   reg       strap_ok_q;
   reg [1:0] role_sel_q;
   reg       sense_q;
   reg       ext_ref_q;
   reg       cfg_en_q;
   reg       user_half_q;
   reg       role_slot0_q;
   reg       start_q;

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         settle_q     <= 3'h0;
         strap_ok_q   <= 1'b0;
         role_sel_q   <= `SCL_ROLE_AUTO;
         sense_q      <= 1'b0;
         ext_ref_q    <= 1'b0;
         cfg_en_q     <= 1'b0;
         user_half_q  <= 1'b0;
         role_slot0_q <= 1'b0;
         start_q      <= 1'b0;
      end
      else
      begin
         start_q <= 1'b0;
         if (!strap_ok_q)
         begin
            settle_q <= settle_q + 3'h1;
            if (settle_q == 3'h7)
            begin
               strap_ok_q  <= 1'b1;
               role_sel_q  <= pin_s2_q[1:0];
               sense_q     <= ~pin_s2_q[2];
               ext_ref_q   <= pin_s2_q[3];
               cfg_en_q    <= pin_s2_q[4];
               user_half_q <= pin_s2_q[5];
               start_q     <= pin_s2_q[4];
               case (pin_s2_q[1:0])
                  `SCL_ROLE_NONSLOT0:
                     role_slot0_q <= 1'b0;
                  `SCL_ROLE_SLOT0:
                     role_slot0_q <= 1'b1;
                  default:
                     role_slot0_q <= ~pin_s2_q[2];
               endcase
            end
         end
      end
   end

// ****************************************************************
// arbiter and loader
// ****************************************************************
   wire        cfg_wr;
   wire [2:0]  cfg_idx;
   wire [15:0] cfg_data;
   wire        load_done;
   wire        arb_busy;

   scl_arbiter u_arb
   (
      .aclk    (aclk),
      .aresetn (aresetn),
      .enable  (role_slot0_q),
      .req     (~pin_s2_q[9:6]),
      .grant   (bus_grant),
      .busy    (arb_busy)
   );

   scl_loader u_load
   (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .start     (start_q),
      .user_half (user_half_q),
      .ee_data   (ee_s2_q),
      .ee_addr   (ee_addr),
      .ee_rd     (ee_rd),
      .cfg_wr    (cfg_wr),
      .cfg_idx   (cfg_idx),
      .cfg_data  (cfg_data),
      .done      (load_done)
   );

   reg [15:0] cfg_q [0:`SCL_CFG_WORDS-1];
   integer    i;

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         for (i = 0; i < `SCL_CFG_WORDS; i = i + 1)
            cfg_q[i] <= 16'h0000;
      end
      else if (cfg_wr)
         cfg_q[cfg_idx] <= cfg_data;
   end

// ****************************************************************
// load deadline watch
// ****************************************************************
   reg [27:0] dl_cnt_q;
   reg        late_q;

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         dl_cnt_q        <= 28'h0000000;
         late_q          <= 1'b0;
         backplane_ready <= 1'b0;
      end
      else
      begin
         backplane_ready <= load_done & cfg_en_q;
         if (!load_done && !late_q)
         begin
            dl_cnt_q <= dl_cnt_q + 28'h0000001;
            if (dl_cnt_q == DEADLINE_CYC[27:0] - 28'h0000001)
               late_q <= cfg_en_q;
         end
      end
   end

// ****************************************************************
// clock steering
// ****************************************************************
   reg [1:0] ctrl_q;

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sysclk_drive_en   <= 1'b0;
         clk10_drive_en    <= 1'b0;
         clk10_ext_sel     <= 1'b0;
         clk10_coax_out_en <= 1'b0;
         clk10_term50_en   <= 1'b0;
      end
      else
      begin
         sysclk_drive_en   <= role_slot0_q;
         clk10_drive_en    <= role_slot0_q;
         clk10_ext_sel     <= role_slot0_q & ext_ref_q;
         clk10_coax_out_en <= ctrl_q[`SCL_CTRL_ROUTE_BIT];
         // termination only matters for an external source
         clk10_term50_en   <= ctrl_q[`SCL_CTRL_TERM_BIT] & role_slot0_q & ext_ref_q;
      end
   end

// ****************************************************************
// axi4-lite slave
// ****************************************************************
   reg        aw_have_q;
   reg        w_have_q;
   reg [7:0]  aw_addr_q;
   reg [31:0] w_data_q;
   reg        w_strb0_q;
   wire       wr_go;
   wire [7:0] status;

   assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
   assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign wr_go         = aw_have_q && w_have_q;
   assign status = {backplane_ready, late_q, load_done, user_half_q,
                    cfg_en_q, ext_ref_q, sense_q, role_slot0_q};

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_have_q    <= 1'b0;
         w_have_q     <= 1'b0;
         aw_addr_q    <= 8'h00;
         w_data_q     <= 32'h00000000;
         w_strb0_q    <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'h0;
         ctrl_q       <= `SCL_CTRL_RESET;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_have_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_have_q  <= 1'b1;
            w_data_q  <= s_axi_wdata;
            w_strb0_q <= s_axi_wstrb[0];
         end
         if (wr_go)
         begin
            aw_have_q    <= 1'b0;
            w_have_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if ({aw_addr_q[7:2], 2'h0} == `SCL_OFF_CTRL)
            begin
               s_axi_bresp <= 2'h0;
               if (w_strb0_q)
                  ctrl_q <= w_data_q[1:0];
            end
            else
               s_axi_bresp <= 2'h2;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // reads answer one cycle after the address is taken
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= 2'h0;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= 2'h0;
         if ({s_axi_araddr[7:2], 2'h0} == `SCL_OFF_CTRL)
            s_axi_rdata <= {30'h00000000, ctrl_q};
         else if ({s_axi_araddr[7:2], 2'h0} == `SCL_OFF_STATUS)
            s_axi_rdata <= {24'h000000, status};
         else if ({s_axi_araddr[7:2], 2'h0} == `SCL_OFF_ARB)
            s_axi_rdata <= {23'h000000, arb_busy, ~pin_s2_q[9:6], bus_grant};
         else if (s_axi_araddr >= `SCL_OFF_CFG_BASE && s_axi_araddr <= `SCL_OFF_CFG_LAST + 8'h3)
            s_axi_rdata <= {16'h0000, cfg_q[s_axi_araddr[4:2]]};
         else
         begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'h2;
         end
      end
      else if (s_axi_rvalid && s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end
endmodule // scl_top

// File: logic/scl_map.vh
// register map, strap encodings and timing constants of the slot role and config loader
`ifndef SCL_MAP_VH
`define SCL_MAP_VH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define SCL_OFF_CTRL        8'h00
`define SCL_OFF_STATUS      8'h04
`define SCL_OFF_ARB         8'h08
`define SCL_OFF_CFG_BASE    8'h20
`define SCL_OFF_CFG_LAST    8'h3c

// ****************************************************************
// field positions
// ****************************************************************
`define SCL_CTRL_ROUTE_BIT  0
`define SCL_CTRL_TERM_BIT   1
`define SCL_CTRL_RESET      2'h0
`define SCL_ST_SLOT0        0
`define SCL_ST_SENSE        1
`define SCL_ST_EXTREF       2
`define SCL_ST_CFGEN        3
`define SCL_ST_USERHALF     4
`define SCL_ST_DONE         5
`define SCL_ST_LATE         6
`define SCL_ST_READY        7

// ****************************************************************
// slot role selector codes
// ****************************************************************
`define SCL_ROLE_AUTO       2'h0
`define SCL_ROLE_NONSLOT0   2'h1
`define SCL_ROLE_SLOT0      2'h2

// ****************************************************************
// eeprom layout and timing
// ****************************************************************
`define SCL_CFG_WORDS       8
`define SCL_EE_ACCESS_NS    200
`define SCL_CLK_HZ          25000000
`define SCL_CLK_NS          40
`define SCL_LOAD_DEADLINE_S 5
`define SCL_SYNC_STAGES     2

`endif

// File: logic/scl_arbiter.v
// data transfer bus arbiter over four request levels
`timescale 1ns/1ps
module scl_arbiter
(
   aclk,
   aresetn,
   enable,
   req,
   grant,
   busy
);
   input  wire       aclk;
   input  wire       aresetn;
   input  wire       enable;
   input  wire [3:0] req;
   output reg  [3:0] grant;
   output wire       busy;

// ****************************************************************
// priority pick, level 3 highest
// ****************************************************************
   function [3:0] pick;
      input [3:0] r;
      begin
         if (r[3])
            pick = 4'h8;
         else if (r[2])
            pick = 4'h4;
         else if (r[1])
            pick = 4'h2;
         else if (r[0])
            pick = 4'h1;
         else
            pick = 4'h0;
      end
   endfunction

   assign busy = |grant;

// ****************************************************************
// grant holding
// ****************************************************************
   // one idle cycle between owners so two grants never overlap
   always @(posedge aclk)
   begin
      if (!aresetn)
         grant <= 4'h0;
      else if (!enable)
         grant <= 4'h0;
      else if (grant == 4'h0)
         grant <= pick(req);
      else if ((grant & req) == 4'h0)
         grant <= 4'h0;
   end
endmodule // scl_arbiter

// File: logic/scl_loader.v
// power-on loader reading one half of the configuration eeprom
`timescale 1ns/1ps
`include "scl_map.vh"
module scl_loader
(
   aclk,
   aresetn,
   start,
   user_half,
   ee_data,
   ee_addr,
   ee_rd,
   cfg_wr,
   cfg_idx,
   cfg_data,
   done
);
   input  wire        aclk;
   input  wire        aresetn;
   input  wire        start;
   input  wire        user_half;
   input  wire [15:0] ee_data;
   output reg  [3:0]  ee_addr;
   output reg         ee_rd;
   output reg         cfg_wr;
   output reg  [2:0]  cfg_idx;
   output reg  [15:0] cfg_data;
   output reg         done;

   // access time rounded up, plus the pin synchroniser delay
   localparam integer ACC_CYC =
      (`SCL_EE_ACCESS_NS + `SCL_CLK_NS - 1) / `SCL_CLK_NS + `SCL_SYNC_STAGES + 1;
   localparam [1:0] S_IDLE = 2'h0;
   localparam [1:0] S_WAIT = 2'h1;
   localparam [1:0] S_NEXT = 2'h2;
   localparam [1:0] S_DONE = 2'h3;

   reg [1:0] state_q;
   reg [3:0] wait_q;

// ****************************************************************
// sequencer
// ****************************************************************
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state_q  <= S_IDLE;
         wait_q   <= 4'h0;
         ee_addr  <= 4'h0;
         ee_rd    <= 1'b0;
         cfg_wr   <= 1'b0;
         cfg_idx  <= 3'h0;
         cfg_data <= 16'h0000;
         done     <= 1'b0;
      end
      else
      begin
         cfg_wr <= 1'b0;
         case (state_q)
            S_IDLE:
               if (start)
               begin
                  ee_addr <= {user_half, 3'h0};
                  ee_rd   <= 1'b1;
                  wait_q  <= ACC_CYC[3:0];
                  cfg_idx <= 3'h0;
                  state_q <= S_WAIT;
               end
            S_WAIT:
               if (wait_q == 4'h0)
               begin
                  cfg_data <= ee_data;
                  cfg_wr   <= 1'b1;
                  state_q  <= S_NEXT;
               end
               else
                  wait_q <= wait_q - 4'h1;
            S_NEXT:
               if (cfg_idx == 3'h7)
               begin
                  ee_rd   <= 1'b0;
                  done    <= 1'b1;
                  state_q <= S_DONE;
               end
               else
               begin
                  cfg_idx <= cfg_idx + 3'h1;
                  ee_addr <= {user_half, cfg_idx + 3'h1};
                  wait_q  <= ACC_CYC[3:0];
                  state_q <= S_WAIT;
               end
            S_DONE:
               state_q <= S_DONE;
            default:
               state_q <= S_IDLE;
         endcase
      end
   end
endmodule // scl_loader

// File: tb/scl_top_sva.sv
// concurrent checks on the ports of the slot role and config loader
`timescale 1ns/1ps
module scl_top_sva
#(
   parameter DEADLINE_CYC = 200
)
(
   input wire        aclk,
   input wire        aresetn,
   input wire [1:0]  s_axi_bresp,
   input wire        s_axi_bvalid,
   input wire        s_axi_bready,
   input wire [31:0] s_axi_rdata,
   input wire        s_axi_rvalid,
   input wire        s_axi_rready,
   input wire [1:0]  slot_role_selector,
   input wire        slot0_sense_n,
   input wire        self_config_enable_jumper,
   input wire        config_half_select_jumper,
   input wire [3:0]  bus_grant,
   input wire        sysclk_drive_en,
   input wire        clk10_drive_en,
   input wire        clk10_ext_sel,
   input wire        clk10_term50_en,
   input wire [3:0]  ee_addr,
   input wire        ee_rd,
   input wire        backplane_ready
);
   int cyc_q;
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // cycles since reset release, saturating so a long run cannot wrap
   always @(posedge aclk)
      if (!aresetn)
         cyc_q <= 0;
      else if (cyc_q < DEADLINE_CYC)
         cyc_q <= cyc_q + 1;
   sequence s_ee_new;
      ee_rd && (!$past(ee_rd) || $changed(ee_addr));
   endsequence
   sequence s_ee_hold;
      $stable(ee_addr) [*6];
   endsequence
   chk_grant_single: assert property ($onehot0(bus_grant))
      else $error("more than one grant");
   chk_grant_gap: assert property ($past(bus_grant) != 4'h0 && bus_grant != $past(bus_grant)
      |-> bus_grant == 4'h0)
      else $error("grant moved without an idle cycle");
   chk_grant_role: assert property (bus_grant != 4'h0 |-> sysclk_drive_en)
      else $error("grant outside controller role");
   chk_clk_pair: assert property (sysclk_drive_en == clk10_drive_en)
      else $error("clock drive enables differ");
   chk_nonslot_quiet: assert property (slot_role_selector == 2'h1 |-> !clk10_drive_en)
      else $error("reference driven in forced non slot 0");
   chk_auto_away: assert property (slot_role_selector[0] == slot_role_selector[1]
      && slot0_sense_n |-> !sysclk_drive_en)
      else $error("auto role took controller outside slot 0");
   chk_ext_slot0: assert property (clk10_ext_sel |-> clk10_drive_en)
      else $error("external source selected outside slot 0");
   chk_term_internal: assert property (clk10_term50_en |-> clk10_ext_sel)
      else $error("termination on with internal source");
   chk_load_enable: assert property (ee_rd |-> self_config_enable_jumper)
      else $error("eeprom read while self configuration off");
   chk_load_half: assert property (ee_rd |-> ee_addr[3] == config_half_select_jumper)
      else $error("eeprom half differs from jumper");
   chk_ee_hold: assert property (s_ee_new |=> s_ee_hold)
      else $error("eeprom address moved during access");
   chk_load_deadline: assert property (cyc_q == DEADLINE_CYC
      && self_config_enable_jumper |-> backplane_ready)
      else $error("backplane not ready by deadline");
   chk_ready_cause: assert property (backplane_ready |-> self_config_enable_jumper && !ee_rd)
      else $error("ready without finished load");
   chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
endmodule // scl_top_sva

bind scl_top scl_top_sva #(.DEADLINE_CYC(DEADLINE_CYC)) i_sva
(
   .aclk(aclk), .aresetn(aresetn), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .slot_role_selector(slot_role_selector),
   .slot0_sense_n(slot0_sense_n), .self_config_enable_jumper(self_config_enable_jumper),
   .config_half_select_jumper(config_half_select_jumper), .bus_grant(bus_grant),
   .sysclk_drive_en(sysclk_drive_en), .clk10_drive_en(clk10_drive_en),
   .clk10_ext_sel(clk10_ext_sel), .clk10_term50_en(clk10_term50_en), .ee_addr(ee_addr),
   .ee_rd(ee_rd), .backplane_ready(backplane_ready)
);

// File: tb/scl_ee_model.sv
// behavioural configuration eeprom with a settable read latency
`timescale 1ns/1ps
module scl_ee_model
#(
   parameter LAT = 1
)
(
   input  wire        aclk,
   input  wire [3:0]  ee_addr,
   input  wire        ee_rd,
   output reg  [15:0] ee_data
);
   reg [3:0] addr_q = 4'h0;
   int       cnt_q = 0;
   initial
      ee_data = 16'h0;
   // idle or settling data toggles every cycle so a stale word cannot pass for a good one
   always @(posedge aclk)
   begin
      addr_q <= ee_addr;
      if (!ee_rd || ee_addr != addr_q)
         cnt_q <= 0;
      else if (cnt_q < LAT)
         cnt_q <= cnt_q + 1;
      if (ee_rd && cnt_q >= LAT)
         ee_data <= {ee_addr, ~ee_addr, 4'h6, ee_addr ^ 4'h9};
      else
         ee_data <= ~ee_data;
   end
endmodule // scl_ee_model

// File: tb/scl_top_tb.sv
// self-checking bench for the slot role and config loader
`timescale 1ns/1ps
module scl_top_tb;
   logic        aclk, rstn = 1'b0, awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
   logic        sense_n = 1'b1, ext = 1'b0, en = 1'b1, half = 1'b1;
   logic [7:0]  awa = 8'h00, ara = 8'h00;
   logic [31:0] wd = 32'h0, rd_v, lfsr = 32'h76217ec6;
   logic [1:0]  sel = 2'h0, rsp;
   logic [3:0]  req_n = 4'hf, act, g_exp;
   wire         awr, wr, bv, arr, rv, sc_en, c10_en, x_sel, coax, term, ee_rd, rdy;
   wire  [1:0]  br, rr;
   wire  [31:0] rdat;
   wire  [3:0]  grant, ee_a;
   wire  [15:0] ee_d;
   int          fail_count = 0, n_compared = 0;
   scl_top #(.DEADLINE_CYC(200)) i_dut
   (
      .aclk(aclk), .aresetn(rstn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
      .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
      .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
      .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
      .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .slot_role_selector(sel),
      .slot0_sense_n(sense_n), .ref_clock_source_switch(ext),
      .self_config_enable_jumper(en), .config_half_select_jumper(half), .bus_req_n(req_n),
      .bus_grant(grant), .sysclk_drive_en(sc_en), .clk10_drive_en(c10_en),
      .clk10_ext_sel(x_sel), .clk10_coax_out_en(coax), .clk10_term50_en(term),
      .ee_data(ee_d), .ee_addr(ee_a), .ee_rd(ee_rd), .backplane_ready(rdy)
   );
   scl_ee_model #(.LAT(1)) i_ee (.aclk(aclk), .ee_addr(ee_a), .ee_rd(ee_rd), .ee_data(ee_d));
   initial
   begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end
   function automatic logic [31:0] nxt(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   function automatic logic [3:0] top_req(input logic [3:0] r);
      return r[3] ? 4'h8 : r[2] ? 4'h4 : r[1] ? 4'h2 : {3'h0, r[0]};
   endfunction
   task automatic final_report();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e)
      begin
         $display("mismatch %s expected %h seen %h", nm, e, g);
         fail_count++;
      end
   endtask
   task automatic hang(input int n);
      if (n >= 64)
      begin
         $display("mismatch wait expected answer seen none");
         fail_count++;
         final_report();
      end
   endtask
   task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge aclk);
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bry <= 1'b1;
      do
      begin
         @(posedge aclk);
         n++;
         if (awr)
            awv <= 1'b0;
         if (wr)
            wv <= 1'b0;
      end while (bv !== 1'b1 && n < 64);
      hang(n);
      r = br;
      bry <= 1'b0;
   endtask
   task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge aclk);
      ara <= a;
      arv <= 1'b1;
      rry <= 1'b1;
      do
      begin
         @(posedge aclk);
         n++;
         if (arr)
            arv <= 1'b0;
      end while (rv !== 1'b1 && n < 64);
      hang(n);
      d = rdat;
      r = rr;
      rry <= 1'b0;
   endtask
   // one power-up with a strap setting; straps only move while reset is held
   task automatic run(input logic [1:0] s, input logic sn, x, e, h);
      logic        s0;
      logic [31:0] m;
      int          n;
      s0 = (s == 2'h2) || (s != 2'h1 && !sn);
      m = 32'hff;
      @(posedge aclk);
      rstn <= 1'b0;
      sel <= s;
      sense_n <= sn;
      ext <= x;
      en <= e;
      half <= h;
      req_n <= 4'hf;
      repeat (3) @(posedge aclk);
      rstn <= 1'b1;
      n = 0;
      while (rdy !== 1'b1 && n < 300)
      begin
         @(posedge aclk);
         n++;
      end
      hang(e ? n / 4 : 0);
      repeat (4) @(posedge aclk);
      chk("sysclk_drive_en", {31'h0, s0}, {31'h0, sc_en});
      chk("clk10_drive_en", {31'h0, s0}, {31'h0, c10_en});
      chk("clk10_ext_sel", {31'h0, s0 & x}, {31'h0, x_sel});
      chk("backplane_ready", {31'h0, e}, {31'h0, rdy});
      chk("clk10_coax_out_en", 32'h0, {31'h0, coax});
      axw(8'h00, 32'h3, rsp);
      chk("ctrl write resp", 32'h0, {30'h0, rsp});
      repeat (3) @(posedge aclk);
      chk("clk10_coax_out_en", 32'h1, {31'h0, coax});
      chk("clk10_term50_en", {31'h0, s0 & x}, {31'h0, term});
      axr(8'h04, rd_v, rsp);
      chk("status", {24'h0, e, 1'b0, e, h, e, x, ~sn, s0} & m, rd_v & m);
      axr(8'h10, rd_v, rsp);
      chk("unmapped read", 32'h2, rd_v | {30'h0, rsp});
      axw(8'h10, 32'h0, rsp);
      chk("unmapped write resp", 32'h2, {30'h0, rsp});
      axw(8'h04, 32'h0, rsp);
      chk("status write resp", 32'h2, {30'h0, rsp});
      axr(8'h00, rd_v, rsp);
      chk("ctrl", 32'h3, rd_v);
      for (n = 0; n < 8 && e; n++)
      begin
         axr(8'h20 + 8'(4 * n), rd_v, rsp);
         m[3:0] = {h, 3'(n)};
         chk("cfg word", {16'h0, m[3:0], ~m[3:0], 4'h6, m[3:0] ^ 4'h9}, rd_v);
      end
      act = s0 ? (lfsr[3:0] | 4'h1) : 4'hf;
      lfsr = nxt(lfsr);
      req_n <= ~act;
      repeat (6) @(posedge aclk);
      g_exp = s0 ? top_req(act) : 4'h0;
      chk("grant", {28'h0, g_exp}, {28'h0, grant});
      req_n <= 4'h0;
      act = 4'hf;
      repeat (6) @(posedge aclk);
      while (act != 4'h0)
      begin
         chk("grant held", {28'h0, g_exp}, {28'h0, grant});
         axr(8'h08, rd_v, rsp);
         chk("arb grant", {23'h0, |g_exp, act, g_exp}, rd_v);
         act = s0 ? act & ~g_exp : 4'h0;
         req_n <= ~act;
         repeat (6) @(posedge aclk);
         g_exp = top_req(act);
      end
      chk("grant idle", 32'h0, {28'h0, grant});
   endtask
   initial
   begin
      run(2'h0, 1'b0, 1'b0, 1'b1, 1'b1);
      run(2'h0, 1'b1, 1'b1, 1'b1, 1'b0);
      run(2'h1, 1'b0, 1'b1, 1'b1, 1'b1);
      run(2'h2, 1'b1, 1'b1, 1'b1, 1'b0);
      run(2'h3, 1'b0, 1'b1, 1'b0, 1'b1);
      repeat (6)
      begin
         run(lfsr[1:0], lfsr[2], lfsr[3], lfsr[4], lfsr[5]);
         lfsr = nxt(lfsr);
      end
      final_report();
   end
endmodule // scl_top_tb
